//--- logic/daq_ctl_pkg.sv
// Constants shared by the acquisition control and interrupt logic
package daq_ctl_pkg;

    // ----------------------------------------
    // Register offsets (word addresses)
    // ----------------------------------------
    localparam logic [3:0] ADDR_CONFIG       = 4'h8;
    localparam logic [3:0] ADDR_INT_ENABLE   = 4'h9;
    localparam logic [3:0] ADDR_INT_FLAGS    = 4'ha;
    localparam logic [3:0] ADDR_LIMIT_STATUS = 4'hd;

    // ----------------------------------------
    // Configuration field positions
    // ----------------------------------------
    localparam int CFG_START      = 0;
    localparam int CFG_RESET      = 1;
    localparam int CFG_SHORT_AZ   = 2;
    localparam int CFG_FULL_CAL   = 3;
    localparam int CFG_STANDBY    = 4;
    localparam int CFG_SIGN_FILL  = 5;
    localparam int CFG_AZ_EACH    = 6;
    localparam int CFG_SYNC_OUT   = 7;
    localparam int CFG_SECTION_LO = 8;
    localparam int CFG_TEST       = 10;
    localparam int CFG_DIAG       = 11;

    // ----------------------------------------
    // Interrupt enable field positions
    // ----------------------------------------
    localparam int IE_MATCH_LO = 8;
    localparam int IE_FIFO_LO  = 11;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [15:0] CONFIG_RESET     = 16'h0000;
    localparam logic [15:0] INT_ENABLE_RESET = 16'h0000;
    localparam logic [1:0]  RESET_HOLD       = 2'h2;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          SETTLE_TIME_MS   = 10;
    localparam int          SETTLE_CYCLES    = SETTLE_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // ----------------------------------------
    // Multiplexer routing codes
    // ----------------------------------------
    localparam logic [3:0] MUX_GND      = 4'h8;
    localparam logic [3:0] MUX_REF_OUT  = 4'h9;
    localparam logic [3:0] MUX_REF_POS  = 4'ha;
    localparam logic [3:0] MUX_REF_NEG  = 4'hb;

    typedef enum logic [1:0]
    {
        PWR_ACTIVE  = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SETTLE  = 2'b10
    } power_e;

endpackage

//--- logic/daq_control_and_interrupt_logic.sv
// Configuration, standby and interrupt logic of the acquisition converter
`timescale 1ns/1ns
// Function
// - Standby gates the core clock off; instruction RAM keeps its contents.
// - Leaving standby gives the same state as a system reset command.
// - After leaving standby wait about 10 ms, then raise interrupt 7.
// - Instruction RAM stays reachable by the host during standby.
// - Config bit 5 picks sign copy or instruction pointer for result bits 13-15.
// - Config bit 6 requests a single-sample auto-zero before every conversion.
// - Config bit 7 sets sync pin direction; input rising edge starts conversion.
// - Sync output is high from conversion start until it finishes.
// - Config bits 8-9 select which 16-bit instruction section is accessed.
// - Diagnostic bit with test clear remaps channel codes 000 and 001.
// - Eight equal interrupt sources; enable bits 0-7 gate them onto the pin.
// - Status flags set on their condition regardless of enable bits.
// - Limit hit raises interrupt 0; limit status records limit and instruction.
// - Interrupt 1 is set before executing the instruction matching enable bits 8-10.
// - Match value 000 skips the first fetch of instruction 0 after a start.
// - Interrupt 2 when FIFO count equals enable bits 11-15, values 1 to 31.
// - Interrupt 3 on short auto-zero done, interrupt 4 on full calibration done.
// - Sequencer runs on after a match; a pause instruction raises interrupt 5.
// - Interrupt 6 when the supply monitor reports low supply.
// - Reading status or a device reset clears flags 0-7.
// - Status bits 8-10 show instruction address, 11-15 the FIFO count.
module daq_control_and_interrupt_logic
    import daq_ctl_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CS_N,
    input  wire logic        RD_N,
    input  wire logic        WR_N,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] DATA_IN,
    output logic      [15:0] DATA_OUT,
    output logic             DATA_OE,
    output logic             INT_N,
    output logic             CORE_CLK_EN,
    output logic             SEQ_RESET,
    output logic             START_REQ,
    output logic             STOP_REQ,
    output logic             SHORT_AZ_REQ,
    output logic             FULL_CAL_REQ,
    output logic             AUTO_ZERO_EACH,
    output logic      [1:0]  RAM_SECTION,
    output logic             RAM_ACCESS_EN,
    input  wire logic        SEQ_RUNNING,
    input  wire logic        SEQ_FETCH,
    input  wire logic [2:0]  SEQ_ADDR,
    input  wire logic        SEQ_PAUSE_HIT,
    input  wire logic        LIMIT1_HIT,
    input  wire logic        LIMIT2_HIT,
    input  wire logic [2:0]  LIMIT_INSTR,
    input  wire logic [5:0]  FIFO_COUNT,
    input  wire logic        SHORT_AZ_DONE,
    input  wire logic        FULL_CAL_DONE,
    input  wire logic        LOW_SUPPLY,
    input  wire logic        CONV_ACTIVE,
    input  wire logic        SYNC_IN,
    output logic             SYNC_OUT,
    output logic             SYNC_OE,
    output logic             SYNC_START,
    input  wire logic        RESULT_VALID,
    input  wire logic [12:0] RESULT_DATA,
    input  wire logic [2:0]  RESULT_PTR,
    output logic      [15:0] FIFO_WORD,
    output logic             FIFO_WORD_VALID,
    input  wire logic [2:0]  CHAN_SEL,
    output logic             DIAG_MODE,
    output logic      [3:0]  MUX_OUT_POSITIVE_SEL,
    output logic      [3:0]  MUX_OUT_NEGATIVE_SEL
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int SETTLE_W = $clog2(SETTLE_COUNT + 1);

    typedef struct packed {
        power_e              pwr;
        logic [15:0]         cfg;
        logic [15:0]         ie;
        logic [7:0]          flags;
        logic [15:0]         limits;
        logic [1:0]          rst_cnt;
        logic [SETTLE_W-1:0] settle;
        logic                first_fetch;
        logic                fifo_eq;
        logic                low_seen;
        logic                sync_seen;
        logic                rd_seen;
        logic                wr_seen;
        logic                az_busy;
        logic                cal_busy;
        logic [15:0]         rdata;
        logic [15:0]         fifo_word;
        logic                fifo_valid;
    } state_s;

    state_s s;
    state_s next_s;

    logic       rd_go;
    logic       wr_go;
    logic       reset_clear;
    logic       fifo_match;
    logic [7:0] ev;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_s = s;
        rd_go = !CS_N && !RD_N && !s.rd_seen;
        wr_go = !CS_N && !WR_N && !s.wr_seen;
        next_s.rd_seen = !CS_N && !RD_N;
        next_s.wr_seen = !CS_N && !WR_N;
        reset_clear = 1'b0;
        ev = 8'h00;
        START_REQ = 1'b0;
        STOP_REQ = 1'b0;
        SHORT_AZ_REQ = 1'b0;
        FULL_CAL_REQ = 1'b0;
        if (s.rst_cnt != 2'h0)
        begin
            next_s.rst_cnt = s.rst_cnt - 2'h1;
        end

        // Bus stays live in standby so RAM section pointer can be moved
        if (wr_go && ADDR == ADDR_CONFIG)
        begin
            next_s.cfg = DATA_IN;
            START_REQ = DATA_IN[CFG_START];
            STOP_REQ = !DATA_IN[CFG_START];
            SHORT_AZ_REQ = DATA_IN[CFG_SHORT_AZ];
            FULL_CAL_REQ = DATA_IN[CFG_FULL_CAL];
            if (DATA_IN[CFG_START] && !SEQ_RUNNING)
            begin
                next_s.first_fetch = 1'b1;
            end
            if (DATA_IN[CFG_RESET])
            begin
                reset_clear = 1'b1;
                next_s.rst_cnt = RESET_HOLD;
            end
            if (DATA_IN[CFG_SHORT_AZ])
            begin
                next_s.az_busy = 1'b1;
            end
            if (DATA_IN[CFG_FULL_CAL])
            begin
                next_s.cal_busy = 1'b1;
            end
        end
        if (wr_go && ADDR == ADDR_INT_ENABLE)
        begin
            next_s.ie = DATA_IN;
        end

        // Power sequencing
        case (s.pwr)
            PWR_ACTIVE:
            begin
                if (s.cfg[CFG_STANDBY])
                begin
                    next_s.pwr = PWR_STANDBY;
                end
            end
            PWR_STANDBY:
            begin
                if (!s.cfg[CFG_STANDBY])
                begin
                    next_s.pwr = PWR_SETTLE;
                    next_s.settle = SETTLE_W'(SETTLE_COUNT);
                    next_s.rst_cnt = RESET_HOLD;
                    reset_clear = 1'b1;
                end
            end
            PWR_SETTLE:
            begin
                if (s.cfg[CFG_STANDBY])
                begin
                    next_s.pwr = PWR_STANDBY;
                end
                else if (s.settle <= SETTLE_W'(1))
                begin
                    next_s.pwr = PWR_ACTIVE;
                    ev[7] = 1'b1;
                end
                else
                begin
                    next_s.settle = s.settle - SETTLE_W'(1);
                end
            end
            default:
            begin
                next_s.pwr = PWR_ACTIVE;
            end
        endcase

        // Interrupt sources
        fifo_match = FIFO_COUNT == {1'b0, s.ie[15:IE_FIFO_LO]} && s.ie[15:IE_FIFO_LO] != 5'h00;
        next_s.fifo_eq = fifo_match;
        next_s.low_seen = LOW_SUPPLY;
        ev[0] = LIMIT1_HIT || LIMIT2_HIT;
        ev[1] = SEQ_FETCH && SEQ_ADDR == s.ie[10:IE_MATCH_LO]
                && !(s.ie[10:IE_MATCH_LO] == 3'h0 && s.first_fetch);
        ev[2] = fifo_match && !s.fifo_eq;
        ev[3] = SHORT_AZ_DONE;
        ev[4] = FULL_CAL_DONE;
        ev[5] = SEQ_PAUSE_HIT;
        ev[6] = LOW_SUPPLY && !s.low_seen;
        if (SEQ_FETCH && SEQ_ADDR == 3'h0)
        begin
            next_s.first_fetch = 1'b0;
        end
        if (SHORT_AZ_DONE)
        begin
            next_s.az_busy = 1'b0;
        end
        if (FULL_CAL_DONE)
        begin
            next_s.cal_busy = 1'b0;
        end

        // Set wins over a clear in the same cycle
        if (reset_clear || (rd_go && ADDR == ADDR_INT_FLAGS))
        begin
            next_s.flags = 8'h00;
        end
        next_s.flags = next_s.flags | ev;
        if (reset_clear || (rd_go && ADDR == ADDR_LIMIT_STATUS))
        begin
            next_s.limits = 16'h0000;
        end
        if (LIMIT1_HIT)
        begin
            next_s.limits[LIMIT_INSTR] = 1'b1;
        end
        if (LIMIT2_HIT)
        begin
            next_s.limits[{1'b1, LIMIT_INSTR}] = 1'b1;
        end
        if (reset_clear)
        begin
            next_s.first_fetch = 1'b1;
        end

        // Read data
        if (rd_go)
        begin
            case (ADDR)
                ADDR_CONFIG:
                begin
                    next_s.rdata = {s.cfg[15:5], s.cfg[CFG_STANDBY], s.cal_busy, s.az_busy,
                                    s.rst_cnt != 2'h0 || s.pwr == PWR_STANDBY, SEQ_RUNNING};
                end
                ADDR_INT_ENABLE:   next_s.rdata = s.ie;
                ADDR_INT_FLAGS:    next_s.rdata = {FIFO_COUNT[4:0], SEQ_ADDR, s.flags};
                ADDR_LIMIT_STATUS: next_s.rdata = s.limits;
                default:           next_s.rdata = 16'h0000;
            endcase
        end

        // Result word upper bits
        next_s.fifo_valid = RESULT_VALID;
        if (RESULT_VALID)
        begin
            next_s.fifo_word = {s.cfg[CFG_SIGN_FILL] ? {3{RESULT_DATA[12]}} : RESULT_PTR,
                                RESULT_DATA};
        end

        next_s.sync_seen = SYNC_IN;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            s <= '0;
            s.pwr <= PWR_ACTIVE;
            s.cfg <= CONFIG_RESET;
            s.ie <= INT_ENABLE_RESET;
            s.first_fetch <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign DATA_OUT = s.rdata;
    assign DATA_OE = !CS_N && !RD_N;
    assign INT_N = !(|(s.flags & s.ie[7:0]));
    assign CORE_CLK_EN = s.pwr != PWR_STANDBY;
    assign SEQ_RESET = s.rst_cnt != 2'h0 || s.pwr == PWR_STANDBY;
    assign AUTO_ZERO_EACH = s.cfg[CFG_AZ_EACH];
    assign RAM_SECTION = s.cfg[CFG_SECTION_LO+1:CFG_SECTION_LO];
    assign RAM_ACCESS_EN = 1'b1;
    assign SYNC_OE = s.cfg[CFG_SYNC_OUT];
    assign SYNC_OUT = s.cfg[CFG_SYNC_OUT] && CONV_ACTIVE;
    assign SYNC_START = !s.cfg[CFG_SYNC_OUT] && SYNC_IN && !s.sync_seen;
    assign FIFO_WORD = s.fifo_word;
    assign FIFO_WORD_VALID = s.fifo_valid;
    assign DIAG_MODE = s.cfg[CFG_DIAG] && !s.cfg[CFG_TEST];

    // Only codes 000 and 001 are rerouted in diagnostic mode
    always_comb
    begin
        MUX_OUT_POSITIVE_SEL = {1'b0, CHAN_SEL};
        MUX_OUT_NEGATIVE_SEL = (CHAN_SEL == 3'h0) ? MUX_GND : {1'b0, CHAN_SEL};
        if (DIAG_MODE && CHAN_SEL == 3'h0)
        begin
            MUX_OUT_POSITIVE_SEL = MUX_REF_OUT;
        end
        else if (DIAG_MODE && CHAN_SEL == 3'h1)
        begin
            MUX_OUT_POSITIVE_SEL = MUX_REF_POS;
            MUX_OUT_NEGATIVE_SEL = MUX_REF_NEG;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_int_pin_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (|(ev & s.ie[7:0])) && !(wr_go && ADDR == ADDR_INT_ENABLE) |=> !INT_N)
        else $error("Interrupt pin not low with enabled flag");
    a_standby_gates: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(s.cfg[CFG_STANDBY]) && s.pwr == PWR_ACTIVE |=> !CORE_CLK_EN)
        else $error("Core clock not gated in standby");
    a_exit_reset: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.pwr == PWR_STANDBY && !s.cfg[CFG_STANDBY] |=> SEQ_RESET && s.flags[7] == 1'b0)
        else $error("Standby exit did not reset");
    a_settle_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.pwr == PWR_SETTLE && s.settle > SETTLE_W'(1) && !s.cfg[CFG_STANDBY]
        |=> s.pwr == PWR_SETTLE && $stable(s.flags[7]))
        else $error("Standby completion too early");
    a_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.flags[3] && !(rd_go && ADDR == ADDR_INT_FLAGS) && !reset_clear |=> s.flags[3])
        else $error("Flag lost without clear");
    a_read_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_go && ADDR == ADDR_INT_FLAGS && ev == 8'h00 |=> s.flags == 8'h00)
        else $error("Status read did not clear flags");
    a_match_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        SEQ_FETCH && SEQ_ADDR == s.ie[10:8] && s.ie[10:8] != 3'h0 |=> s.flags[1])
        else $error("Instruction match flag missing");
    a_first_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        SEQ_FETCH && SEQ_ADDR == 3'h0 && s.ie[10:8] == 3'h0 && s.first_fetch && !s.flags[1]
        |=> !s.flags[1])
        else $error("First fetch of instruction zero flagged");
    a_fifo_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(fifo_match) |=> s.flags[2])
        else $error("FIFO level flag missing");
    a_sign_fill: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RESULT_VALID && s.cfg[CFG_SIGN_FILL] |=> FIFO_WORD[15:13] == {3{FIFO_WORD[12]}})
        else $error("Sign fill wrong");
    a_sync_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.cfg[CFG_SYNC_OUT] |-> SYNC_OUT == CONV_ACTIVE && SYNC_OE)
        else $error("Sync output does not follow conversion");

endmodule

//--- test/daq_host_model.sv
// Host processor model that drives the parallel register bus
`timescale 1ns/1ns
module daq_host_model
    import daq_ctl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] data_out,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic      [3:0]  addr,
    output logic      [15:0] data_in
);
    initial
    begin
        {cs_n, rd_n, wr_n} = 3'b111;
        addr = 4'h0;
        data_in = 16'h0000;
    end

    // Strobes rise half a cycle after the take edge; lines then show junk
    task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic rd,
                       output logic [15:0] q);
        @(negedge sys_clk);
        cs_n <= 1'b0;
        rd_n <= !rd;
        wr_n <= rd;
        addr <= a;
        data_in <= (a == ADDR_CONFIG) ? (d & 16'hfbff) : d;
        @(negedge sys_clk);
        {cs_n, rd_n, wr_n} <= 3'b111;
        addr <= ~a;
        data_in <= ~d;
        @(negedge sys_clk);
        q = data_out;
    endtask

    task automatic set_mask(input logic [15:0] d);
        logic [15:0] q;
        bus(ADDR_INT_ENABLE, d, 1'b0, q);
        bus(ADDR_INT_FLAGS, 16'h0000, 1'b1, q);
    endtask
endmodule

//--- test/daq_control_and_interrupt_logic_test.sv
// Self-checking bench for the control and interrupt logic
`timescale 1ns/1ns
module daq_control_and_interrupt_logic_test
    import daq_ctl_pkg::*;
;
    localparam int SETTLE = 20;
    logic        sys_clk, rst_n, cs_n, rd_n, wr_n, int_n, core_clk_en, seq_reset;
    logic        auto_zero_each, ram_access_en, seq_fetch, seq_pause_hit, limit1_hit;
    logic        limit2_hit, short_az_done, full_cal_done, low_supply, conv_active;
    logic        sync_in, sync_out, sync_oe, sync_start, result_valid, fifo_word_valid;
    logic        diag_mode, seq_running;
    logic [1:0]  ram_section;
    logic [2:0]  seq_addr, limit_instr, result_ptr, chan_sel;
    logic [3:0]  addr, mux_pos, mux_neg;
    logic [5:0]  fifo_count;
    logic [12:0] result_data;
    logic [15:0] data_in, data_out, fifo_word;
    int          miscompares;
    int          n_compared;

    daq_control_and_interrupt_logic #(.SETTLE_COUNT(SETTLE)) i_daq_control_and_interrupt_logic
    (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr),
        .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(), .INT_N(int_n),
        .CORE_CLK_EN(core_clk_en), .SEQ_RESET(seq_reset), .START_REQ(), .STOP_REQ(),
        .SHORT_AZ_REQ(), .FULL_CAL_REQ(), .AUTO_ZERO_EACH(auto_zero_each),
        .RAM_SECTION(ram_section), .RAM_ACCESS_EN(ram_access_en), .SEQ_RUNNING(seq_running),
        .SEQ_FETCH(seq_fetch), .SEQ_ADDR(seq_addr), .SEQ_PAUSE_HIT(seq_pause_hit),
        .LIMIT1_HIT(limit1_hit), .LIMIT2_HIT(limit2_hit), .LIMIT_INSTR(limit_instr),
        .FIFO_COUNT(fifo_count), .SHORT_AZ_DONE(short_az_done),
        .FULL_CAL_DONE(full_cal_done), .LOW_SUPPLY(low_supply), .CONV_ACTIVE(conv_active),
        .SYNC_IN(sync_in), .SYNC_OUT(sync_out), .SYNC_OE(sync_oe), .SYNC_START(sync_start),
        .RESULT_VALID(result_valid), .RESULT_DATA(result_data), .RESULT_PTR(result_ptr),
        .FIFO_WORD(fifo_word), .FIFO_WORD_VALID(fifo_word_valid), .CHAN_SEL(chan_sel),
        .DIAG_MODE(diag_mode), .MUX_OUT_POSITIVE_SEL(mux_pos), .MUX_OUT_NEGATIVE_SEL(mux_neg)
    );

    daq_host_model i_daq_host_model
    (
        .sys_clk(sys_clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_daq_host_model.bus(a, d, 1'b0, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        i_daq_host_model.bus(a, 16'h0000, 1'b1, q);
    endtask

    // Levels (fifo count, low supply) stay up until the caller drops them
    task automatic fire(input int i);
        @(negedge sys_clk);
        case (i)
            0: limit1_hit = 1'b1;
            1: seq_fetch = 1'b1;
            2: fifo_count = 6'd1;
            3: short_az_done = 1'b1;
            4: full_cal_done = 1'b1;
            5: seq_pause_hit = 1'b1;
            6: low_supply = 1'b1;
            default: limit2_hit = 1'b1;
        endcase
        @(negedge sys_clk);
        {limit1_hit, limit2_hit, seq_fetch, short_az_done, full_cal_done, seq_pause_hit} = '0;
    endtask

    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic reset_test;
        logic [15:0] q;
        check_bit(int_n, 1'b1);
        check_bit(core_clk_en, 1'b1);
        check_bit(seq_reset, 1'b0);
        rd(ADDR_INT_ENABLE, q);
        check_word(q, INT_ENABLE_RESET);
        rd(ADDR_INT_FLAGS, q);
        check_word(q, 16'h0000);
        wr(4'h3, 16'hffff);
        rd(4'h3, q);
        check_word(q, 16'h0000);
    endtask

    task automatic flags_test;
        logic [15:0] q;
        seq_addr = 3'd3;
        for (int i = 0; i < 7; i++)
            for (int j = 0; j < 2; j++)
            begin
                i_daq_host_model.set_mask({5'd1, 3'd3, j ? ~8'(1 << i) : 8'(1 << i)});
                fire(i);
                @(negedge sys_clk);
                check_bit(int_n, j[0]);
                rd(ADDR_INT_FLAGS, q);
                check_word(q, {fifo_count[4:0], seq_addr, 8'(1 << i)});
                check_bit(int_n, 1'b1);
                fifo_count = 6'd0;
                low_supply = 1'b0;
            end
    endtask

    task automatic match_test;
        logic [15:0] q;
        logic [2:0]  m;
        for (int k = 0; k < 2; k++)
        begin
            m = k ? 3'd7 : 3'd0;
            i_daq_host_model.set_mask({5'd0, m, 8'h02});
            wr(ADDR_CONFIG, 16'h0001);
            seq_addr = k ? 3'd6 : 3'd0;
            fire(1);
            rd(ADDR_INT_FLAGS, q);
            check_word(q, {5'd0, seq_addr, 8'h00});
            seq_addr = m;
            fire(1);
            rd(ADDR_INT_FLAGS, q);
            check_word(q, {5'd0, seq_addr, 8'h02});
        end
    endtask

    task automatic limit_test;
        logic [15:0] q;
        // Limit 1 of instruction 0 is left over from the flag scenario
        rd(ADDR_LIMIT_STATUS, q);
        check_word(q, 16'h0001);
        limit_instr = 3'd3;
        fire(0);
        limit_instr = 3'd6;
        fire(7);
        rd(ADDR_LIMIT_STATUS, q);
        check_word(q, 16'h4008);
        rd(ADDR_LIMIT_STATUS, q);
        check_word(q, 16'h0000);
        rd(ADDR_INT_FLAGS, q);
        check_word(q, {5'd0, seq_addr, 8'h01});
    endtask

    task automatic command_test;
        logic [15:0] q;
        fire(3);
        wr(ADDR_CONFIG, 16'h0002);
        check_bit(seq_reset, 1'b1);
        rd(ADDR_INT_FLAGS, q);
        check_word(q, {5'd0, seq_addr, 8'h00});
        wr(ADDR_CONFIG, 16'h0004);
        seq_running = 1'b1;
        rd(ADDR_CONFIG, q);
        check_word(q, 16'h0005);
        seq_running = 1'b0;
        fire(3);
        rd(ADDR_CONFIG, q);
        check_word(q, 16'h0000);
    endtask

    task automatic config_test;
        logic [15:0] q;
        for (int s = 0; s < 3; s++)
        begin
            wr(ADDR_CONFIG, {6'h00, 2'(s), 8'h40});
            check_word({14'h0000, ram_section}, 16'(s));
            check_bit(auto_zero_each, 1'b1);
            rd(ADDR_CONFIG, q);
            check_word(q, {6'h00, 2'(s), 8'h40});
        end
        wr(ADDR_CONFIG, 16'h0000);
        check_bit(auto_zero_each, 1'b0);
    endtask

    task automatic result_test(input logic [15:0] cfg, input logic [15:0] exp);
        wr(ADDR_CONFIG, cfg);
        result_data = 13'h1abc;
        result_ptr = 3'd5;
        result_valid = 1'b1;
        @(negedge sys_clk);
        result_valid = 1'b0;
        result_data = ~result_data;
        for (int n = 0; n < 4 && fifo_word_valid !== 1'b1; n++)
            @(negedge sys_clk);
        check_bit(fifo_word_valid, 1'b1);
        check_word(fifo_word, exp);
    endtask

    task automatic sync_test;
        wr(ADDR_CONFIG, 16'h0000);
        check_bit(sync_oe, 1'b0);
        sync_in = 1'b1;
        // Edge pulse stands only until the next rising edge
        #1;
        for (int n = 0; n < 4 && sync_start !== 1'b1; n++)
            @(negedge sys_clk);
        check_bit(sync_start, 1'b1);
        @(negedge sys_clk);
        check_bit(sync_start, 1'b0);
        sync_in = 1'b0;
        wr(ADDR_CONFIG, 16'h0080);
        check_bit(sync_oe, 1'b1);
        conv_active = 1'b1;
        repeat (2) @(negedge sys_clk);
        check_bit(sync_out, 1'b1);
        conv_active = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_bit(sync_out, 1'b0);
    endtask

    task automatic mux_check(input logic [2:0] c, input logic [7:0] exp);
        chan_sel = c;
        @(negedge sys_clk);
        check_word({8'h00, mux_pos, mux_neg}, {8'h00, exp});
    endtask

    task automatic diag_test;
        wr(ADDR_CONFIG, 16'h0800);
        check_bit(diag_mode, 1'b1);
        mux_check(3'd0, {MUX_REF_OUT, MUX_GND});
        mux_check(3'd1, {MUX_REF_POS, MUX_REF_NEG});
        mux_check(3'd2, 8'h22);
        wr(ADDR_CONFIG, 16'h0000);
        check_bit(diag_mode, 1'b0);
        mux_check(3'd0, {4'h0, MUX_GND});
        mux_check(3'd1, 8'h11);
    endtask

    task automatic standby_test;
        logic [15:0] q;
        int          n;
        i_daq_host_model.set_mask(16'h0080);
        fire(3);
        wr(ADDR_CONFIG, 16'h0010);
        check_bit(core_clk_en, 1'b0);
        check_bit(seq_reset, 1'b1);
        rd(ADDR_INT_ENABLE, q);
        check_word(q, 16'h0080);
        check_bit(ram_access_en, 1'b1);
        wr(ADDR_CONFIG, 16'h0000);
        // No start is issued before completion shows on the pin
        n = 0;
        while (int_n !== 1'b0 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        check_bit(n >= SETTLE - 3 && n <= SETTLE + 2, 1'b1);
        check_bit(seq_reset, 1'b0);
        check_bit(core_clk_en, 1'b1);
        rd(ADDR_INT_FLAGS, q);
        check_word(q, {5'd0, seq_addr, 8'h80});
    endtask

    // ----------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_n = 1'b0;
        {seq_fetch, seq_pause_hit, limit1_hit, limit2_hit, short_az_done} = '0;
        {full_cal_done, low_supply, conv_active, sync_in, result_valid, seq_running} = '0;
        {seq_addr, limit_instr, result_ptr, chan_sel, fifo_count, result_data} = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        reset_test();
        flags_test();
        match_test();
        limit_test();
        command_test();
        config_test();
        result_test(16'h0020, 16'hfabc);
        result_test(16'h0000, 16'hbabc);
        sync_test();
        diag_test();
        standby_test();
        wrap_up();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        wrap_up();
    end
endmodule
